//--- logic/rsc_device.sv
// Purpose: Reset source controller, device end.
// Assumes: Events on clk_sys; pin and detectors are not.
// Notes:   Power-up through rst_n is treated like a power-on reset.
//
// What this block does
// - Any of seven sources asserts reset
// - On release load PC from bytes 0,1
// - Opcode FFH resets, except under debug
// - Pin held low at least 10 us
// - Internal resets end alone; pin waits high
// - CPU resumes on fast internal oscillator
// - Reset stops oscillators, clocks, CPU, peripherals
// - Reset-out low; debug pin floats or pulls
// - Detector resets release when supply recovers
// - Detector reset spares detector; others stop it
// - PC reloaded; parity disable, port latch cleared
// - Eight-bit read-only cause flag register
// - Each internal source sets its flag only
// - Pin, power-on reset, byte read clear flags
// - Software reads flags only as bytes
// - Every reset re-enables parity resets
// - Software initialises RAM before parity use
// - Software drives reset-out high around reset
// - First release 0.672 or 0.399 ms
// - Later releases 0.531 or 0.259 ms
// - Stabilization wait 0.99 ms after power-up
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"
module rsc_device #(
    parameter int unsigned STAB_CYC        = `RSC_STAB_NS / `RSC_CLK_NS,
    parameter int unsigned FIRST_LVD_CYC   = `RSC_FIRST_LVD_NS / `RSC_CLK_NS,
    parameter int unsigned FIRST_NOLVD_CYC =
        `RSC_FIRST_NOLVD_NS / `RSC_CLK_NS,
    parameter int unsigned LATER_LVD_CYC   = `RSC_LATER_LVD_NS / `RSC_CLK_NS,
    parameter int unsigned LATER_NOLVD_CYC =
        `RSC_LATER_NOLVD_NS / `RSC_CLK_NS
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    rsc_link_if.device         link,
    output logic               sys_reset,
    output logic               osc_stop,
    output logic               ext_clk_ignore,
    output logic               periph_halt,
    output logic               fast_osc_sel,
    output logic               lvd_stop,
    output rsc_pkg::rsc_word_t pc_value,
    output logic               cpu_run
);
    import rsc_pkg::*;

    // ************************************************************
    // Source conditioning
    // ************************************************************
    logic [2:0]  lvl_s;
    logic        ext_req;
    logic        por_req;
    logic        lvd_req;
    logic        level_req;
    logic        wdt_ev;
    logic        illop_ev;
    logic        par_ev;
    logic        acc_ev;
    logic        int_ev;
    rsc_state_t  state_r;
    rsc_state_t  state_nxt;
    logic [17:0] cnt_r;
    logic [17:0] cnt_nxt;
    logic [17:0] proc_cyc;
    logic        first_r;
    logic        stab_r;
    logic        pin_kind_r;
    logic        lvd_kind_r;
    logic        parity_dis_r;
    logic        port_high_r;
    rsc_byte_t   flags_r;
    rsc_byte_t   flag_rdata_r;
    rsc_word_t   pc_r;

    // Pin and detectors are asynchronous to clk_sys
    rsc_sync2 #(.WIDTH(3), .INIT(3'h7)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     ({~link.reset_pin_n, link.por_low, link.lvd_low}),
        .dout    (lvl_s)
    );

    assign ext_req  = lvl_s[2];
    assign por_req  = lvl_s[1];
    // Only while enabled and not stopped
    assign lvd_req  = lvl_s[0] & link.lvd_enable & ~lvd_stop;
    assign level_req = ext_req | por_req | lvd_req;

    // Internal sources only count while the CPU runs
    assign wdt_ev   = cpu_run & link.wdt_ovf;
    assign illop_ev = cpu_run & link.op_fetch & ~link.debug_mode
                    & (link.opcode == `RSC_ILLEGAL_OPCODE);
    assign par_ev   = cpu_run & link.parity_err & ~parity_dis_r;
    assign acc_ev   = cpu_run & link.illegal_acc;
    assign int_ev   = wdt_ev | illop_ev | par_ev | acc_ev;

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    // First release after power-up waits longer
    assign proc_cyc = first_r ? (link.lvd_enable ? 18'(FIRST_LVD_CYC)
        : 18'(FIRST_NOLVD_CYC))
        : link.lvd_enable ? 18'(LATER_LVD_CYC)
        : 18'(LATER_NOLVD_CYC);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            RSC_HOLD: begin
                // Pin reset waits for the pin; internal ones do not
                if (!level_req) begin
                    if (stab_r) begin
                        state_nxt = RSC_STAB;
                        cnt_nxt   = 18'(STAB_CYC - 1);
                    end else begin
                        state_nxt = RSC_PROC;
                        cnt_nxt   = proc_cyc - 18'h00001;
                    end
                end
            end
            RSC_STAB: begin
                if (cnt_r == 18'h00000) begin
                    state_nxt = RSC_PROC;
                    cnt_nxt   = proc_cyc - 18'h00001;
                end else begin
                    cnt_nxt = cnt_r - 18'h00001;
                end
            end
            RSC_PROC: begin
                if (cnt_r == 18'h00000) begin
                    state_nxt = RSC_RUN;
                end else begin
                    cnt_nxt = cnt_r - 18'h00001;
                end
            end
            RSC_RUN: state_nxt = RSC_RUN;
            default: state_nxt = RSC_HOLD;
        endcase
        // Any request restarts the whole sequence
        if (level_req || int_ev) begin
            state_nxt = RSC_HOLD;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= RSC_HOLD;
            cnt_r   <= 18'h00000;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Power-up history selects the long waits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            first_r <= 1'b1;
            stab_r  <= 1'b1;
        end else if (por_req) begin
            first_r <= 1'b1;
            stab_r  <= 1'b1;
        end else begin
            if (state_r == RSC_PROC && state_nxt == RSC_RUN) begin
                first_r <= 1'b0;
            end
            if (state_r == RSC_STAB && state_nxt == RSC_PROC) begin
                stab_r <= 1'b0;
            end
        end
    end

    // Kind of the reset in progress, for pins and detector
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_kind_r <= 1'b1;
            lvd_kind_r <= 1'b0;
        end else if (level_req || int_ev) begin
            pin_kind_r <= ext_req | por_req;
            lvd_kind_r <= lvd_req & ~ext_req & ~por_req & ~int_ev;
        end
    end

    // ************************************************************
    // Clock, halt and program counter
    // ************************************************************
    assign sys_reset      = (state_r != RSC_RUN);
    assign cpu_run        = (state_r == RSC_RUN);
    assign osc_stop       = (state_r == RSC_HOLD);
    assign ext_clk_ignore = (state_r == RSC_HOLD);
    assign periph_halt    = sys_reset;
    // Other clock choices are made by software after release
    assign fast_osc_sel   = 1'b1;
    // Detector runs on through its own reset only
    assign lvd_stop       = sys_reset & ~lvd_kind_r;

    // PC is reloaded at release; every reset also clears the parity disable and the port latch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= 16'h0000;
        end else if (state_r == RSC_PROC && state_nxt == RSC_RUN) begin
            pc_r <= {link.vec_hi, link.vec_lo};
        end
    end
    assign pc_value = pc_r;

    // ************************************************************
    // Cause flags and parity control
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= `RSC_FLAG_RESET;
        end else if (ext_req || por_req) begin
            flags_r <= `RSC_FLAG_RESET;
        end else begin
            // Read clear first, so a same-cycle event survives
            if (link.flag_rd) begin
                flags_r <= `RSC_FLAG_RESET;
            end
            // Held bits stay; internal resets touch only their own
            if (illop_ev) flags_r[`RSC_FLAG_ILLOP] <= 1'b1;
            if (wdt_ev) flags_r[`RSC_FLAG_WDT] <= 1'b1;
            if (par_ev) flags_r[`RSC_FLAG_PARITY] <= 1'b1;
            if (acc_ev) flags_r[`RSC_FLAG_ACCESS] <= 1'b1;
            if (lvd_req && !lvd_stop) begin
                flags_r[`RSC_FLAG_VOLT] <= 1'b1;
            end
        end
    end

    // Byte read; unused bits are never set and read zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_rdata_r <= 8'h00;
        end else if (link.flag_rd) begin
            flag_rdata_r <= flags_r;
        end
    end
    assign link.flag_rdata = flag_rdata_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            parity_dis_r <= 1'b0;
        end else if (sys_reset) begin
            parity_dis_r <= 1'b0;
        end else if (link.prd_wr) begin
            parity_dis_r <= link.prd_wdata;
        end
    end

    // ************************************************************
    // Port pins
    // ************************************************************
    // Latch falls in reset, so the pin can reset external parts
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_high_r <= 1'b0;
        end else if (sys_reset) begin
            port_high_r <= 1'b0;
        end else if (link.port_set_high) begin
            port_high_r <= 1'b1;
        end
    end
    // Latch clears a cycle late; gate so the pin is low at once
    assign link.reset_out_o  = port_high_r & ~sys_reset;
    assign link.reset_out_oe = 1'b1;
    // Pull-up modelled as a weak high drive
    assign link.debug_o      = 1'b1;
    assign link.debug_oe     = ~(sys_reset & pin_kind_r);
endmodule : rsc_device
`default_nettype wire

//--- logic/rsc_params.svh
// Purpose: Offsets, field positions, reset values and times of the
//          reset source controller.
// Assumes: 100 MHz system clock.
// Notes:   Times in ns.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

`define RSC_CLK_NS          10
// Cause flag register, bit positions
`define RSC_FLAG_OFFSET     20'hFFFA8
`define RSC_FLAG_ILLOP      7
`define RSC_FLAG_WDT        4
`define RSC_FLAG_PARITY     2
`define RSC_FLAG_ACCESS     1
`define RSC_FLAG_VOLT       0
`define RSC_FLAG_RESET      8'h00
`define RSC_ILLEGAL_OPCODE  8'hFF
// Release processing, typical figures
`define RSC_FIRST_LVD_NS    672000
`define RSC_FIRST_NOLVD_NS  399000
`define RSC_LATER_LVD_NS    531000
`define RSC_LATER_NOLVD_NS  259000
`define RSC_STAB_NS         990000
`define RSC_EXT_MIN_NS      10000
// Host APB register offsets
`define RSC_CTRL_OFFSET     12'h000
`define RSC_EVT_OFFSET      12'h004
`define RSC_VEC_OFFSET      12'h008
`define RSC_STAT_OFFSET     12'h00C
// Host CTRL fields
`define RSC_CTRL_PIN_LOW    0
`define RSC_CTRL_POR_LOW    1
`define RSC_CTRL_LVD_LOW    2
`define RSC_CTRL_LVD_EN     3
`define RSC_CTRL_DEBUG      4
`define RSC_CTRL_PRD        5
`define RSC_CTRL_RESET      16'h0001
// Host EVT fields, write one to pulse
`define RSC_EVT_WDT         0
`define RSC_EVT_FETCH       1
`define RSC_EVT_PARITY      2
`define RSC_EVT_ACCESS      3
`define RSC_EVT_FLAG_RD     4
`define RSC_EVT_PRD_WR      5
`define RSC_EVT_PORT_HIGH   6

`endif

//--- logic/rsc_pkg.sv
// Purpose: Types shared by both ends of the reset source controller.
// Assumes: Nothing.
// Notes:   One-hot state codes.
package rsc_pkg;
    typedef enum logic [3:0] {
        RSC_HOLD = 4'h1,
        RSC_STAB = 4'h2,
        RSC_PROC = 4'h4,
        RSC_RUN  = 4'h8
    } rsc_state_t;
    typedef logic [7:0]  rsc_byte_t;
    typedef logic [15:0] rsc_word_t;
endpackage : rsc_pkg

//--- logic/rsc_link_if.sv
// Purpose: Link between the reset controller and its surroundings.
// Assumes: Both ends on clk_sys; pins are modelled as o/oe pairs.
// Notes:   Wire levels of the pins are not resolved; the host reads o and oe raw.
`timescale 1ns/1ps
`default_nettype none
interface rsc_link_if;
    import rsc_pkg::*;
    logic      reset_pin_n;
    logic      por_low;
    logic      lvd_low;
    logic      lvd_enable;
    logic      debug_mode;
    logic      wdt_ovf;
    logic      op_fetch;
    rsc_byte_t opcode;
    logic      parity_err;
    logic      illegal_acc;
    logic      flag_rd;
    rsc_byte_t flag_rdata;
    logic      prd_wr;
    logic      prd_wdata;
    logic      port_set_high;
    rsc_byte_t vec_lo;
    rsc_byte_t vec_hi;
    logic      reset_out_o;
    logic      reset_out_oe;
    logic      debug_o;
    logic      debug_oe;

    modport device (
        input  reset_pin_n, por_low, lvd_low, lvd_enable, debug_mode,
        input  wdt_ovf, op_fetch, opcode, parity_err, illegal_acc,
        input  flag_rd, prd_wr, prd_wdata, port_set_high, vec_lo, vec_hi,
        output flag_rdata, reset_out_o, reset_out_oe, debug_o, debug_oe
    );
    modport host (
        output reset_pin_n, por_low, lvd_low, lvd_enable, debug_mode,
        output wdt_ovf, op_fetch, opcode, parity_err, illegal_acc,
        output flag_rd, prd_wr, prd_wdata, port_set_high, vec_lo, vec_hi,
        input  flag_rdata, reset_out_o, reset_out_oe, debug_o, debug_oe
    );
endinterface : rsc_link_if
`default_nettype wire

//--- logic/rsc_sync2.sv
// Purpose: Two-flop synchroniser for levels from outside the clock.
// Assumes: Inputs are slow levels.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module rsc_sync2 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            dout   <= INIT;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : rsc_sync2
`default_nettype wire

//--- logic/rsc_host.sv
// Purpose: Surroundings of the reset controller, steered over APB.
// Assumes: Zero-wait APB slave on clk_sys.
// Notes:   Unmapped addresses answer with pslverr.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"
module rsc_host #(
    parameter int unsigned EXT_MIN_CYC =
        (`RSC_EXT_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    rsc_link_if.host         link
);
    import rsc_pkg::*;

    // ************************************************************
    // APB registers
    // ************************************************************
    logic        acc;
    logic        hit;
    rsc_word_t   ctrl_r;
    rsc_word_t   vec_r;
    logic [6:0]  evt_r;
    logic        rd_pend_r;
    rsc_byte_t   flags_seen_r;
    logic        pin_low_r;
    logic [9:0]  min_cnt_r;

    assign acc    = psel & penable;
    assign pready = 1'b1;
    assign hit    = (paddr == `RSC_CTRL_OFFSET) || (paddr == `RSC_EVT_OFFSET)
                 || (paddr == `RSC_VEC_OFFSET) || (paddr == `RSC_STAT_OFFSET);
    assign pslverr = acc & ~hit;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `RSC_CTRL_RESET;
            vec_r  <= 16'h0000;
        end else if (acc && pwrite) begin
            if (paddr == `RSC_CTRL_OFFSET) begin
                ctrl_r <= pwdata[15:0];
            end else if (paddr == `RSC_VEC_OFFSET) begin
                vec_r <= pwdata[15:0];
            end
        end
    end

    // Event strobes last exactly one cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_r <= 7'h00;
        end else if (acc && pwrite && paddr == `RSC_EVT_OFFSET) begin
            evt_r <= pwdata[6:0];
        end else begin
            evt_r <= 7'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `RSC_CTRL_OFFSET) begin
                prdata <= {16'h0000, ctrl_r};
            end else if (paddr == `RSC_VEC_OFFSET) begin
                prdata <= {16'h0000, vec_r};
            end else if (paddr == `RSC_STAT_OFFSET) begin
                prdata <= {19'h00000, link.debug_oe, link.reset_out_oe,
                           link.reset_out_o, pin_low_r, flags_seen_r};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Flag byte is captured one cycle after the read strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_r    <= 1'b0;
            flags_seen_r <= 8'h00;
        end else begin
            rd_pend_r <= evt_r[`RSC_EVT_FLAG_RD];
            if (rd_pend_r) begin
                flags_seen_r <= link.flag_rdata;
            end
        end
    end

    // ************************************************************
    // Reset pin with minimum low time
    // ************************************************************
    // Pin stays low at power-up and never rises before the minimum
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_low_r <= 1'b1;
            min_cnt_r <= 10'h000;
        end else if (pin_low_r) begin
            if (min_cnt_r < 10'(EXT_MIN_CYC - 1)) begin
                min_cnt_r <= min_cnt_r + 10'h001;
            end else if (!ctrl_r[`RSC_CTRL_PIN_LOW]) begin
                pin_low_r <= 1'b0;
            end
        end else if (ctrl_r[`RSC_CTRL_PIN_LOW]) begin
            pin_low_r <= 1'b1;
            min_cnt_r <= 10'h000;
        end
    end

    // ************************************************************
    // Link drive
    // ************************************************************
    assign link.reset_pin_n   = ~pin_low_r;
    assign link.por_low       = ctrl_r[`RSC_CTRL_POR_LOW];
    assign link.lvd_low       = ctrl_r[`RSC_CTRL_LVD_LOW];
    assign link.lvd_enable    = ctrl_r[`RSC_CTRL_LVD_EN];
    assign link.debug_mode    = ctrl_r[`RSC_CTRL_DEBUG];
    assign link.opcode        = ctrl_r[15:8];
    assign link.wdt_ovf       = evt_r[`RSC_EVT_WDT];
    assign link.op_fetch      = evt_r[`RSC_EVT_FETCH];
    // Software must have initialised the RAM before enabling this
    assign link.parity_err    = evt_r[`RSC_EVT_PARITY];
    assign link.illegal_acc   = evt_r[`RSC_EVT_ACCESS];
    assign link.flag_rd       = evt_r[`RSC_EVT_FLAG_RD];
    assign link.prd_wr        = evt_r[`RSC_EVT_PRD_WR];
    assign link.prd_wdata     = ctrl_r[`RSC_CTRL_PRD];
    assign link.port_set_high = evt_r[`RSC_EVT_PORT_HIGH];
    assign link.vec_lo        = vec_r[7:0];
    assign link.vec_hi        = vec_r[15:8];
endmodule : rsc_host
`default_nettype wire

//--- dv/rsc_assertions.sv
// Purpose: Checks on the link between both controller ends.
// Assumes: One clock domain; short release counts (at least 8).
// Notes:   Internal events count only while the CPU runs.
`timescale 1ns/1ps
`default_nettype none
module rsc_assertions (
    input wire logic               clk_sys,
    input wire logic               rst_n,
    input wire logic               wdt_ovf,
    input wire logic               op_fetch,
    input wire rsc_pkg::rsc_byte_t opcode,
    input wire logic               debug_mode,
    input wire logic               parity_err,
    input wire logic               illegal_acc,
    input wire logic               prd_wr,
    input wire logic               prd_wdata,
    input wire rsc_pkg::rsc_byte_t vec_lo,
    input wire rsc_pkg::rsc_byte_t vec_hi,
    input wire logic               reset_out_o,
    input wire logic               reset_out_oe,
    input wire logic               debug_o,
    input wire logic               debug_oe,
    input wire logic               sys_reset,
    input wire logic               osc_stop,
    input wire logic               periph_halt,
    input wire logic               fast_osc_sel,
    input wire rsc_pkg::rsc_word_t pc_value,
    input wire logic               cpu_run
);
    import rsc_pkg::*;
    logic par_off_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Shadow of the parity disable bit; any reset clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) par_off_r <= 1'h0;
        else if (sys_reset) par_off_r <= 1'h0;
        else if (prd_wr) par_off_r <= prd_wdata;
    end
    sequence s_evt;
        cpu_run && (wdt_ovf || illegal_acc);
    endsequence
    sequence s_hold;
        sys_reset [*8];
    endsequence
    a_event_reset: assert property (s_evt |=> sys_reset)
        else $error("internal event gave no reset");
    a_illop_reset: assert property (cpu_run && op_fetch
        && opcode == 8'hFF && !debug_mode |=> sys_reset)
        else $error("illegal opcode gave no reset");
    a_parity_arm: assert property (cpu_run && parity_err
        && !par_off_r |=> sys_reset)
        else $error("parity error gave no reset");
    a_resout_low: assert property (sys_reset |->
        !reset_out_o && reset_out_oe)
        else $error("reset output not low in reset");
    a_debug_pull: assert property (s_evt |=> debug_oe && debug_o)
        else $error("debug pin not pulled high");
    a_osc_halt: assert property (osc_stop |-> sys_reset && periph_halt)
        else $error("oscillators stopped outside reset");
    a_reset_hold: assert property ($rose(sys_reset) |-> s_hold)
        else $error("reset shorter than processing");
    a_release_run: assert property ($fell(sys_reset) |->
        cpu_run && fast_osc_sel)
        else $error("release without fast clock run");
    a_pc_vector: assert property ($rose(cpu_run) |->
        pc_value == {vec_hi, vec_lo})
        else $error("pc not loaded from vector");
endmodule : rsc_assertions
`default_nettype wire

//--- dv/tb_reset_source_control.sv
// Purpose: Bench driving both controller ends over APB.
// Assumes: Short release counts; zero-wait slave.
// Notes:   Reads are compared in order from a queue.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_source_control;
    import rsc_pkg::*;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        sys_reset, cpu_run, fast_osc_sel, osc_stop, periph_halt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rng;
    logic [64:0] cur;
    logic [64:0] exp_q[$];
    rsc_word_t   pc_value;
    int          n_fail, checked;
    rsc_link_if link ();
    rsc_host #(.EXT_MIN_CYC(4)) rsc_host_inst (.clk_sys(clk_sys),
        .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    rsc_device #(.STAB_CYC(6), .FIRST_NOLVD_CYC(10),
        .LATER_LVD_CYC(9), .LATER_NOLVD_CYC(8)) rsc_device_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .sys_reset(sys_reset), .osc_stop(osc_stop), .ext_clk_ignore(),
        .periph_halt(periph_halt), .fast_osc_sel(fast_osc_sel),
        .lvd_stop(), .pc_value(pc_value), .cpu_run(cpu_run));
    rsc_assertions rsc_assertions_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .wdt_ovf(link.wdt_ovf), .op_fetch(link.op_fetch),
        .opcode(link.opcode), .debug_mode(link.debug_mode),
        .parity_err(link.parity_err), .illegal_acc(link.illegal_acc),
        .prd_wr(link.prd_wr), .prd_wdata(link.prd_wdata),
        .vec_lo(link.vec_lo), .vec_hi(link.vec_hi),
        .reset_out_o(link.reset_out_o), .reset_out_oe(link.reset_out_oe),
        .debug_o(link.debug_o), .debug_oe(link.debug_oe),
        .sys_reset(sys_reset), .osc_stop(osc_stop),
        .periph_halt(periph_halt), .fast_osc_sel(fast_osc_sel),
        .pc_value(pc_value), .cpu_run(cpu_run));
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [32:0] e, s);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Master holds the request until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 50);
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) begin n_fail++; stop_test(); end
        @(posedge clk_sys);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
                      input logic err);
        exp_q.push_back({err, m, e});
        apb(a, 1'h0, 32'h0);
    endtask : rd
    task automatic flags(input logic [7:0] f);
        apb(12'h004, 1'h1, 32'h10);
        repeat (3) @(posedge clk_sys);
        rd(12'h00C, 32'hFF, {24'h0, f}, 1'h0);
    endtask : flags
    // Reset must be seen to start, then to end by itself
    task automatic wait_run;
        int n;
        n = 0;
        while (cpu_run === 1'h1 && n < 10) begin @(posedge clk_sys); n++; end
        chk("reset seen", 33'h0, {32'h0, cpu_run});
        while (cpu_run !== 1'h1 && n < 300) begin @(posedge clk_sys); n++; end
        if (n >= 300) begin n_fail++; stop_test(); end
    endtask : wait_run
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) chk("queue", 33'h0, 33'h1);
            else begin
                cur = exp_q.pop_front();
                chk("read", {cur[64], cur[31:0]},
                    {pslverr, prdata & cur[63:32]});
            end
        end
    end
    initial begin
        rst_n = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        n_fail = 0;
        checked = 0;
        rng = xs(32'h364F);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        apb(12'h008, 1'h1, {16'h0, rng[15:0]});
        apb(12'h000, 1'h1, 32'hFF00);
        wait_run();
        chk("pc", {17'h0, rng[15:0]}, {17'h0, pc_value});
        flags(8'h00);
        for (int k = 0; k < 4; k++) begin
            apb(12'h004, 1'h1, 32'h1 << k);
            wait_run();
        end
        flags(8'h96);
        flags(8'h00);
        apb(12'h000, 1'h1, 32'hFF30);
        apb(12'h004, 1'h1, 32'h20);
        apb(12'h004, 1'h1, 32'h6);
        repeat (6) @(posedge clk_sys);
        chk("running", 33'h1, {32'h0, cpu_run});
        apb(12'h004, 1'h1, 32'h1);
        wait_run();
        apb(12'h004, 1'h1, 32'h4);
        wait_run();
        flags(8'h14);
        apb(12'h004, 1'h1, 32'h40);
        repeat (3) @(posedge clk_sys);
        rd(12'h00C, 32'h200, 32'h200, 1'h0);
        apb(12'h004, 1'h1, 32'h1);
        wait_run();
        apb(12'h000, 1'h1, 32'h1);
        repeat (8) @(posedge clk_sys);
        rd(12'h00C, 32'hF00, 32'h500, 1'h0);
        apb(12'h000, 1'h1, 32'h0);
        wait_run();
        flags(8'h00);
        apb(12'h000, 1'h1, 32'hC);
        repeat (8) @(posedge clk_sys);
        apb(12'h000, 1'h1, 32'h8);
        wait_run();
        flags(8'h01);
        rd(12'h010, 32'hFFFFFFFF, 32'h0, 1'h1);
        stop_test();
    end
endmodule : tb_reset_source_control
`default_nettype wire
